// file: sld_core.sv
// Serial latched LED sink logic: shift register, latches and blanking
// Overview of operation
// - Each rising serial clock edge loads serial data into stage zero.
// - Each rising serial clock edge moves every stage one step toward serial out.
// - While latch enable is high, each latch copies its shift stage.
// - Latches stay transparent and follow the shift stages while latch enable is high.
// - Output enable high switches every sink off regardless of latches.
// - Output enable never changes latch contents.
// - Output enable low drives each sink from its own latch.
`timescale 1ns/10ps
module sld_core (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_ser_data,
  input wire logic i_ser_clock,
  input wire logic i_latch_en,
  input wire logic i_out_blank,
  output logic o_ser_data,
  output logic [15:0] o_sink_on
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  sld_pkg::sld_pins_t raw;
  sld_pkg::sld_pins_t pins;
  logic data_lvl;
  logic clock_lvl;
  logic latch_lvl;
  logic blank_lvl;

  assign raw = '{data: i_ser_data, clock: i_ser_clock, latch_en: i_latch_en,
                 blank: i_out_blank};
  // Each filtered level has one driver; the struct only carries them together
  assign pins = '{data: data_lvl, clock: clock_lvl, latch_en: latch_lvl,
                  blank: blank_lvl};

  // Filtered levels lag their pins by four clock edges
  sld_sync u_sync_data (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_pin(raw.data),
    .i_init(1'b0),
    .o_level(data_lvl)
  );

  sld_sync u_sync_clock (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_pin(raw.clock),
    .i_init(1'b0),
    .o_level(clock_lvl)
  );

  sld_sync u_sync_latch (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_pin(raw.latch_en),
    .i_init(1'b0),
    .o_level(latch_lvl)
  );

  sld_sync u_sync_blank (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_pin(raw.blank),
    .i_init(1'b0),
    .o_level(blank_lvl)
  );

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic clk_prev;
    logic [15:0] shift;
    logic [15:0] latch;
    logic [15:0] sink;
    logic sdo;
  } sld_core_state_t;

  sld_core_state_t st_q;
  sld_core_state_t st_d;
  logic rise;
  logic [15:0] shift_next;

  // ------------------------------------------------------------
  // Serial clock edge detection
  // ------------------------------------------------------------
  // Previous level resets low like the idle serial clock, so reset makes no false edge
  assign rise = pins.clock & ~st_q.clk_prev;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.clk_prev = pins.clock;

    // Shift register: data enters stage zero, stage 15 leaves toward serial out
    shift_next = st_q.shift;
    if (rise) begin
      shift_next = {st_q.shift[14:0], pins.data};
    end
    st_d.shift = shift_next;

    // Transparent latch: follows the updated stages while enabled
    // Closed latches keep their value; blanking has no path into them
    if (pins.latch_en) begin
      st_d.latch = shift_next;
    end

    // Sinks: blanking gates the drivers only, after the latches
    if (pins.blank) begin
      st_d.sink = '0;
    end else begin
      st_d.sink = st_d.latch;
    end

    // Cascade output mirrors the last stage
    st_d.sdo = shift_next[sld_pkg::LAST_STAGE];
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      st_q.clk_prev <= 1'b0;
      st_q.shift <= sld_pkg::SHIFT_RESET;
      st_q.latch <= sld_pkg::LATCH_RESET;
      st_q.sink <= sld_pkg::SINK_RESET;
      st_q.sdo <= 1'b0;
    end else if (i_ce) begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign o_ser_data = st_q.sdo;
  assign o_sink_on = st_q.sink;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  shift_capture_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && rise) |=> st_q.shift[0] == $past(pins.data))
    else $error("stage zero missed serial data");

  shift_move_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && rise) |=> st_q.shift[15:1] == $past(st_q.shift[14:0]))
    else $error("shift did not advance");

  shift_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && !rise) |=> $stable(st_q.shift))
    else $error("shift moved without edge");

  latch_copy_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && pins.latch_en) |=> st_q.latch == st_q.shift)
    else $error("latch not transparent");

  latch_follow_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && pins.latch_en && rise) |=> st_q.latch[0] == $past(pins.data))
    else $error("latch did not follow new data");

  latch_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && !pins.latch_en) |=> $stable(st_q.latch))
    else $error("latch changed while closed");

  blank_keep_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && !pins.latch_en && $changed(pins.blank)) |=> $stable(st_q.latch))
    else $error("blanking disturbed latches");

  blank_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && pins.blank) |=> o_sink_on == 16'h0000)
    else $error("sinks on while blanked");

  sink_follow_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && !pins.blank) |=> o_sink_on == st_q.latch)
    else $error("sinks differ from latches");

  cascade_out_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && rise) |=> o_ser_data == $past(st_q.shift[14]))
    else $error("serial out not last stage");

  cascade_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && !rise) |=> $stable(o_ser_data))
    else $error("serial out moved without edge");

  edge_once_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && rise) |=> !rise)
    else $error("one serial clock edge seen twice");

  blank_latch_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && pins.latch_en && pins.blank) |=> st_q.latch == st_q.shift)
    else $error("blanking stopped latch update");

  sink_open_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && pins.latch_en && !pins.blank) |=> o_sink_on == st_q.shift)
    else $error("open latch sinks differ from stages");

  sink_closed_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ce && !pins.latch_en && !pins.blank) |=> o_sink_on == $past(st_q.latch))
    else $error("closed latch sinks changed");

  // Clock enable low freezes every register, synchronisers included
  freeze_state_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !i_ce |=> $stable(st_q))
    else $error("state moved while clock enable low");

  // Reset check runs during reset itself, so it has no disable
  reset_clear_a: assert property (@(posedge i_clock)
    !i_rst_b |=> (o_sink_on == sld_pkg::SINK_RESET && o_ser_data == 1'b0))
    else $error("outputs not cleared by reset");
endmodule : sld_core

// file: sld_pkg.sv
// Package of constants and carrier types for the serial latched LED sink logic
package sld_pkg;
  localparam int unsigned NUM_OUTPUTS = 16;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [15:0] SINK_RESET = 16'h0000;
  localparam int unsigned LAST_STAGE = 15;

  // Pin levels, carried both raw and after synchronisation
  typedef struct packed {
    logic data;
    logic clock;
    logic latch_en;
    logic blank;
  } sld_pins_t;
endpackage : sld_pkg

// file: sld_sync.sv
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/10ps
module sld_sync (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_pin,
  input wire logic i_init,
  output logic o_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sld_sync_state_t;

  sld_sync_state_t st_q;
  sld_sync_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = i_pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // A change counts once the second and third stages agree
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      // Every stage starts at the pin's idle level, so reset makes no false change
      st_q <= '{s1: i_init, s2: i_init, s3: i_init, lvl: i_init};
    end else if (i_ce) begin
      st_q <= st_d;
    end
  end

  assign o_level = st_q.lvl;
endmodule : sld_sync

// file: sld_host.sv
// Host controller model driving the serial data and serial clock pins
`timescale 1ns/10ps
module sld_host (
  output logic o_ser_data,
  output logic o_ser_clock
);
  initial begin
    o_ser_data = 1'b0;
    o_ser_clock = 1'b0;
  end
  // ----------
  // Frame
  // ----------
  // Sends a word first bit first; the serial clock rests low between frames
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      o_ser_data = w[i];
      #200 o_ser_clock = 1'b1;
      #200 o_ser_clock = 1'b0;
    end
    o_ser_data = ~o_ser_data;
  endtask : send_word
endmodule : sld_host

// file: tb_top.sv
// Self-checking bench for the serial latched LED sink logic
`timescale 1ns/10ps
module tb_top;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_latch_en = 1'b1;
  logic i_out_blank = 1'b0;
  logic ce = 1'b1;
  logic ser_data;
  logic ser_clock;
  logic o_ser_data;
  logic [15:0] o_sink_on;
  int error_cnt = 0;
  int compares = 0;
  always #25 i_clock = ~i_clock;
  sld_host sld_host_inst (.o_ser_data(ser_data), .o_ser_clock(ser_clock));
  sld_core sld_core_inst (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_ce(ce),
    .i_ser_data(ser_data), .i_ser_clock(ser_clock), .i_latch_en(i_latch_en),
    .i_out_blank(i_out_blank), .o_ser_data(o_ser_data), .o_sink_on(o_sink_on));
  // ----------
  // Helpers
  // ----------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic settle();
    repeat (8) @(posedge i_clock);
    #1;
  endtask : settle
  task automatic test_done();
    if (error_cnt == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // ----------
  // Scenarios
  // ----------
  task automatic t_load();
    i_out_blank = 1'b1;
    sld_host_inst.send_word(16'ha5c3);
    settle();
    chk("blanked load", o_sink_on, 16'h0000);
    i_out_blank = 1'b0;
    settle();
    chk("sinks", o_sink_on, 16'ha5c3);
    chk("ser out", {15'h0000, o_ser_data}, 16'h0001);
  endtask : t_load
  task automatic t_hold();
    i_latch_en = 1'b0;
    sld_host_inst.send_word(16'h3c0f);
    settle();
    chk("held sinks", o_sink_on, 16'ha5c3);
    chk("ser out", {15'h0000, o_ser_data}, 16'h0000);
    i_latch_en = 1'b1;
    settle();
    i_latch_en = 1'b0;
    settle();
    chk("latched sinks", o_sink_on, 16'h3c0f);
  endtask : t_hold
  task automatic t_blank();
    i_out_blank = 1'b1;
    settle();
    chk("blanked", o_sink_on, 16'h0000);
    i_out_blank = 1'b0;
    settle();
    chk("unblanked", o_sink_on, 16'h3c0f);
  endtask : t_blank
  task automatic t_freeze();
    ce = 1'b0;
    i_out_blank = 1'b1;
    settle();
    chk("frozen sinks", o_sink_on, 16'h3c0f);
    ce = 1'b1;
    settle();
    chk("thawed blank", o_sink_on, 16'h0000);
    i_out_blank = 1'b0;
    settle();
    chk("thawed sinks", o_sink_on, 16'h3c0f);
  endtask : t_freeze
  task automatic t_reset();
    i_rst_b = 1'b0;
    i_latch_en = 1'b1;
    settle();
    chk("mid reset sinks", o_sink_on, 16'h0000);
    chk("mid reset ser out", {15'h0000, o_ser_data}, 16'h0000);
    i_rst_b = 1'b1;
    i_out_blank = 1'b1;
    sld_host_inst.send_word(16'h8001);
    i_out_blank = 1'b0;
    settle();
    chk("reloaded sinks", o_sink_on, 16'h8001);
    chk("reloaded ser out", {15'h0000, o_ser_data}, 16'h0001);
  endtask : t_reset
  initial begin
    repeat (16) @(posedge i_clock);
    #1;
    i_rst_b = 1'b1;
    settle();
    chk("reset sinks", o_sink_on, 16'h0000);
    t_load();
    t_hold();
    t_blank();
    t_freeze();
    t_reset();
    test_done();
  end
endmodule : tb_top
